// ===== hw/spimsp_baud.sv
// Baud generator giving one enable pulse per serial clock half period.
`timescale 1ns/1ps
module spimsp_baud (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Rate selection and run control.
    input  wire logic [2:0] rate,
    input  wire logic       run,
    // Half period enable pulse.
    output logic            tick
);
    logic [6:0] cnt;
    logic [6:0] half;
    logic       valid;

    // Divisor 4 << (rate-1) gives a half period of 2 << (rate-1); 000 and 111 have no clock.
    assign valid = (rate != 3'h0) && (rate != 3'h7); // R1
    assign half  = 7'h02 << (rate - 3'h1);

    // The counter restarts while idle so the first half period is always full length.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else if (!run || !valid) begin
            cnt  <= 7'h00;
            tick <= 1'b0;
        end else if (cnt == half - 7'h01) begin
            cnt  <= 7'h00;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 7'h01;
            tick <= 1'b0;
        end
    end
endmodule

// ===== hw/spimsp_pkg.sv
// Package with register indices, field positions and reset values of the serial port.
// ****************************************************************************
// Contract
// [R1] Master clock is peripheral clock over 4..128.
// [R2] External master clock at most quarter system clock.
// [R3] Master fault sets flag, clears enable and master.
// [R4] Fault flag clears by status read, control write.
// [R5] Slave select rising after low flags fault.
// [R6] Slave byte starts at select fall, ends idle.
// [R7] Deselected slave floats output, clears counter, ignores clock.
// [R8] Select disable: slave always selected, no fault.
// [R9] Select disable: master never sees mode fault.
// [R10] Clearing select disable keeps fault flag.
// [R11] Software avoids select disable with phase zero.
// [R12] Overrun keeps old byte, discards new one.
// [R13] Status read clears overrun flag.
// [R14] Done flag set, cleared by status-data sequence.
// [R15] Done requests transmit interrupt when empty-enable clear.
// [R16] Empty flag requests interrupt when empty-enable set.
// [R17] Software drops empty-enable before last reception.
// [R18] Polarity bit sets serial clock idle level.
// [R19] Phase bit picks sampling edge.
// [R20] Fault flag interrupts only when enabled.
// ****************************************************************************
package spimsp_pkg;
    // Register word indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CONTROL   = 8'hd4;
    localparam logic [7:0] IDX_STATUS    = 8'hd5;
    localparam logic [7:0] IDX_DATA      = 8'hd6;
    // Control register fields.
    localparam int         CTL_RATE_HI   = 7;
    localparam int         CTL_ENABLE    = 6;
    localparam int         CTL_SEL_DIS   = 5;
    localparam int         CTL_MASTER    = 4;
    localparam int         CTL_CLOCK_IDLE_POLARITY      = 3;
    localparam int         CTL_CLOCK_SAMPLE_PHASE      = 2;
    localparam int         CTL_RATE_MID  = 1;
    localparam int         CTL_RATE_LO   = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h14;
    // Status and control register fields.
    localparam int         STA_DONE      = 7;
    localparam int         STA_OVERRUN   = 5;
    localparam int         STA_FAULT     = 4;
    localparam int         STA_TX_EMPTY  = 3;
    localparam int         STA_UART_MODE = 2;
    localparam int         STA_TXE_IE    = 1;
    localparam int         STA_FAULT_IE  = 0;
    localparam logic [7:0] STATUS_RESET  = 8'h08;
    // Bits per transfer.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ===== hw/spimsp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module spimsp_sync #(
    parameter int W = 4
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Asynchronous levels in, synchronous levels out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // The first stage feeds only the second stage to keep metastability contained.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ===== hw/spimsp_top.sv
// Serial peripheral port working as master or slave, with a classic Wishbone register slave.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module spimsp_top (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Wishbone slave.
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [9:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Serial clock pin.
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE_N,
    // Master out, slave in pin.
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE_N,
    // Master in, slave out pin.
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE_N,
    // Slave select pin, input only.
    input  wire logic        SS_N_I,
    // Interrupt requests.
    output logic             IRQ_TX,
    output logic             IRQ_FAULT
);
    // Registers, decoded control fields, pin levels and internal strobes.
    logic [7:0] control_reg, rx_data, tx_buf, shifter, done_byte, status_val, next_dat;
    logic [3:0] bit_cnt, pins_s;
    logic [2:0] rate;
    logic       mode_fault_flag, overrun_flag, transfer_done_flag, fault_arm, done_arm;
    logic       uart_style_mode_bit, tx_empty_int_enable, fault_int_enable, tx_full;
    logic       interface_enable_bit, select_pin_disable, master_select_bit;
    logic       clock_idle_polarity, clock_sample_phase, rx_bit, m_busy, sck_q, tick;
    logic       sck_s, mosi_s, miso_s, ss_n_s, sck_prev, ss_prev, selected, lead, trail;
    logic       din, sample_e, shift_e, done, load, in_prog, fault_m, fault_s;
    logic       ack, acc, rd_status, wr_control, data_acc;

    // Word index decode shared by the read mux and the access strobes.
    function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
        hit = (adr[9:2] == idx);
    endfunction

    // ************************************************************************
    // Control fields and pins
    // ************************************************************************
    assign interface_enable_bit = control_reg[spimsp_pkg::CTL_ENABLE];
    assign select_pin_disable   = control_reg[spimsp_pkg::CTL_SEL_DIS];
    assign master_select_bit    = control_reg[spimsp_pkg::CTL_MASTER];
    assign clock_idle_polarity  = control_reg[spimsp_pkg::CTL_CLOCK_IDLE_POLARITY];
    assign clock_sample_phase   = control_reg[spimsp_pkg::CTL_CLOCK_SAMPLE_PHASE];
    assign rate = {control_reg[spimsp_pkg::CTL_RATE_HI],
                   control_reg[spimsp_pkg::CTL_RATE_MID],
                   control_reg[spimsp_pkg::CTL_RATE_LO]};

    // Every pin input crosses into the clock domain through two flops.
    spimsp_sync #(.W(4)) u_sync (
        .clk      (CLK),
        .rst      (RESET),
        .async_in ({SCK_I, MOSI_I, MISO_I, SS_N_I}),
        .sync_out (pins_s)
    );
    assign {sck_s, mosi_s, miso_s, ss_n_s} = pins_s;

    // Select pin disable forces the slave to consider itself selected.
    assign selected = select_pin_disable || !ss_n_s; // R8

    // Master half period enable; stops while no master transfer runs.
    spimsp_baud u_baud (
        .clk  (CLK),
        .rst  (RESET),
        .rate (rate),
        .run  (m_busy),
        .tick (tick)
    );

    // Pin drivers; the enables are low while this port drives a pin.
    assign SCK_O     = sck_q;
    assign MOSI_O    = shifter[7];
    assign MISO_O    = shifter[7];
    assign SCK_OE_N  = !(interface_enable_bit && master_select_bit);
    assign MOSI_OE_N = !(interface_enable_bit && master_select_bit);
    assign MISO_OE_N = !(interface_enable_bit && !master_select_bit && selected); // R7

    // ************************************************************************
    // Clock edges and the bit engine
    // ************************************************************************
    // A master leaves idle when its clock equals the idle level; a slave sees the
    // edges on the synchronised clock, which is why the link must run at most at
    // a quarter of the system clock.
    always_comb begin
        if (master_select_bit) begin
            lead  = m_busy && tick && (sck_q == clock_idle_polarity); // R19
            trail = m_busy && tick && (sck_q != clock_idle_polarity);
            din   = miso_s;
        end else begin
            lead  = interface_enable_bit && selected && (sck_s != sck_prev) // R2 R7
                    && (sck_prev == clock_idle_polarity);
            trail = interface_enable_bit && selected && (sck_s != sck_prev)
                    && (sck_prev != clock_idle_polarity);
            din   = mosi_s;
        end
    end

    // Phase clear samples on the edge leaving idle, phase set on the edge returning.
    assign sample_e  = clock_sample_phase ? trail : lead; // R19
    assign shift_e   = clock_sample_phase ? lead : trail;
    // The byte ends on the edge back to idle that samples the eighth bit under phase set, or follows it under phase clear.
    assign done      = trail && (bit_cnt == (clock_sample_phase ? // R6
                       spimsp_pkg::BITS_PER_BYTE - 4'h1 : spimsp_pkg::BITS_PER_BYTE));
    assign done_byte = {shifter[6:0], clock_sample_phase ? din : rx_bit};
    assign load      = tx_full && !m_busy && (bit_cnt == 4'h0) && !lead && !trail;
    assign in_prog   = m_busy || (!master_select_bit && selected && bit_cnt != 4'h0);

    // Previous levels for the edge detectors, taken from the second sync stage.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sck_prev <= 1'b0;
            ss_prev  <= 1'b1;
        end else begin
            sck_prev <= sck_s;
            ss_prev  <= ss_n_s;
        end
    end

    // Bit counter, cleared on deselect so a broken transfer restarts from scratch.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bit_cnt <= 4'h0;
        end else if (!interface_enable_bit || fault_m || done) begin
            bit_cnt <= 4'h0;
        end else if (!master_select_bit && !selected) begin
            bit_cnt <= 4'h0; // R7
        end else if (sample_e) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // Sampled bit and shift register; the first shift edge under phase set only
    // presents the first bit, so nothing is shifted before a sample exists.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rx_bit  <= 1'b0;
            shifter <= 8'h00;
        end else begin
            if (sample_e) begin
                rx_bit <= din;
            end
            if (load) begin
                shifter <= tx_buf;
            end else if (shift_e && bit_cnt != 4'h0 && bit_cnt != spimsp_pkg::BITS_PER_BYTE) begin
                shifter <= {shifter[6:0], rx_bit};
            end
        end
    end

    // Master transfer state and generated clock, parked at the idle level.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            m_busy <= 1'b0;
            sck_q  <= 1'b0;
        end else begin
            if (fault_m || done || !interface_enable_bit || !master_select_bit) begin
                m_busy <= 1'b0;
            end else if (load) begin
                m_busy <= 1'b1;
            end
            if (!m_busy) begin
                sck_q <= clock_idle_polarity; // R18
            end else if (tick) begin
                sck_q <= !sck_q; // R1
            end
        end
    end

    // ************************************************************************
    // Buffers and mode fault
    // ************************************************************************
    // A data write refills the buffer even in the cycle the old byte is loaded.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_buf  <= 8'h00;
            tx_full <= 1'b0;
        end else if (acc && WE_I && SEL_I[0] && hit(ADR_I, spimsp_pkg::IDX_DATA)) begin
            tx_buf  <= DAT_I[7:0];
            tx_full <= 1'b1;
        end else if (load) begin
            tx_full <= 1'b0; // R16
        end
    end

    // An unread byte is never overwritten; the newer one is dropped instead.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rx_data <= 8'h00;
        end else if (done && !transfer_done_flag) begin
            rx_data <= done_byte; // R12
        end
    end

    // A master with an active select input risks a second master on the bus.
    assign fault_m = interface_enable_bit && master_select_bit && !select_pin_disable // R9
                     && !ss_n_s;
    // A slave faults on any deselect, whether or not clocks arrived.
    assign fault_s = interface_enable_bit && !master_select_bit && !select_pin_disable // R5 R8
                     && ss_n_s && !ss_prev;

    // Set wins over the status-read then control-write clearing sequence.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_fault_flag <= 1'b0;
            fault_arm       <= 1'b0;
        end else begin
            if (fault_m || fault_s) begin
                mode_fault_flag <= 1'b1; // R3
            end else if (wr_control && fault_arm) begin
                mode_fault_flag <= 1'b0; // R4 R10
            end
            if (rd_status && mode_fault_flag) begin
                fault_arm <= 1'b1;
            end else if (wr_control) begin
                fault_arm <= 1'b0;
            end
        end
    end

    // ************************************************************************
    // Register bus
    // ************************************************************************
    // Access takes effect on the edge where the master sees ack high.
    assign acc        = CYC_I && STB_I && ack;
    assign rd_status  = acc && !WE_I && hit(ADR_I, spimsp_pkg::IDX_STATUS);
    assign wr_control = acc && WE_I && SEL_I[0] && hit(ADR_I, spimsp_pkg::IDX_CONTROL);
    assign data_acc   = acc && hit(ADR_I, spimsp_pkg::IDX_DATA);
    assign ACK_O      = ack;

    // Done reads as clear while a byte is on the wire.
    assign status_val = {transfer_done_flag && !in_prog, 1'b0, overrun_flag, // R14
                         mode_fault_flag, !tx_full, uart_style_mode_bit,
                         tx_empty_int_enable, fault_int_enable};

    // Read mux; unmapped words read as zero and are still acknowledged.
    always_comb begin
        next_dat = 8'h00;
        if (hit(ADR_I, spimsp_pkg::IDX_CONTROL)) begin
            next_dat = control_reg;
        end else if (hit(ADR_I, spimsp_pkg::IDX_STATUS)) begin
            next_dat = status_val;
        end else if (hit(ADR_I, spimsp_pkg::IDX_DATA)) begin
            next_dat = rx_data;
        end
    end

    // One wait state: ack follows the request by one cycle and drops after one.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack   <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ack <= CYC_I && STB_I && !ack;
            if (CYC_I && STB_I && !ack) begin
                DAT_O <= {24'h00_0000, next_dat};
            end
        end
    end

    // Control register; a master fault beats a software write in the same cycle.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            control_reg <= spimsp_pkg::CONTROL_RESET;
        end else begin
            if (wr_control) begin
                control_reg <= DAT_I[7:0];
            end
            if (fault_m) begin
                control_reg[spimsp_pkg::CTL_ENABLE] <= 1'b0; // R3
                control_reg[spimsp_pkg::CTL_MASTER] <= 1'b0;
            end
        end
    end

    // Writable status bits: mode bit and the two interrupt enables.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            uart_style_mode_bit <= spimsp_pkg::STATUS_RESET[spimsp_pkg::STA_UART_MODE];
            tx_empty_int_enable <= spimsp_pkg::STATUS_RESET[spimsp_pkg::STA_TXE_IE];
            fault_int_enable    <= spimsp_pkg::STATUS_RESET[spimsp_pkg::STA_FAULT_IE];
        end else if (acc && WE_I && SEL_I[0] && hit(ADR_I, spimsp_pkg::IDX_STATUS)) begin
            uart_style_mode_bit <= DAT_I[spimsp_pkg::STA_UART_MODE];
            tx_empty_int_enable <= DAT_I[spimsp_pkg::STA_TXE_IE];
            fault_int_enable    <= DAT_I[spimsp_pkg::STA_FAULT_IE];
        end
    end

    // Done and overrun flags; a completing byte wins over any clear.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            transfer_done_flag <= 1'b0;
            done_arm           <= 1'b0;
            overrun_flag       <= 1'b0;
        end else begin
            if (done) begin
                transfer_done_flag <= 1'b1; // R14
            end else if (data_acc && done_arm) begin
                transfer_done_flag <= 1'b0;
            end
            if (rd_status && status_val[spimsp_pkg::STA_DONE]) begin
                done_arm <= 1'b1;
            end else if (data_acc) begin
                done_arm <= 1'b0;
            end
            if (done && transfer_done_flag) begin
                overrun_flag <= 1'b1; // R12
            end else if (rd_status) begin
                overrun_flag <= 1'b0; // R13
            end
        end
    end

    // Requests: the empty-enable picks which flag drives the transmit request.
    assign IRQ_TX    = tx_empty_int_enable ? !tx_full : transfer_done_flag; // R15 R16
    assign IRQ_FAULT = mode_fault_flag && fault_int_enable; // R20

    // ************************************************************************
    // Assertions
    // ************************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_RATE_GATED: assert property ((rate == 3'h0 || rate == 3'h7) |-> !tick) // R1
        else $error("baud tick with an unused rate code");
    AST_TICK_SPACING: assert property ((tick && rate == 3'h2) ##1 (m_busy && rate == 3'h2) [*4] // R1
        |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
        else $error("divide by eight rate does not tick every fourth cycle");
    AST_MASTER_FAULT: assert property (fault_m |=> mode_fault_flag && !control_reg[6] && !control_reg[4]) // R3
        else $error("master fault did not disable the port");
    AST_FAULT_CLEAR: assert property ($fell(mode_fault_flag) |-> $past(wr_control) && $past(fault_arm)) // R4
        else $error("fault flag cleared without the clearing sequence");
    AST_SLAVE_FAULT: assert property (fault_s |=> mode_fault_flag) // R5
        else $error("slave deselect did not raise the fault flag");
    AST_DESELECT_FLOAT: assert property ((!master_select_bit && !selected) |-> MISO_OE_N ##1 bit_cnt == 4'h0) // R7
        else $error("deselected slave still drives or counts");
    AST_SELECT_PIN_DISABLE_NO_FAULT: assert property (select_pin_disable |-> !fault_m && !fault_s) // R8
        else $error("fault detected with select pin disabled");
    AST_SELECT_PIN_DISABLE_MASTER: assert property ((select_pin_disable && master_select_bit && !mode_fault_flag && !wr_control) |=> !mode_fault_flag) // R9
        else $error("master fault flag set with select pin disabled");
    AST_OVERRUN_KEEP: assert property ((done && transfer_done_flag) |=> overrun_flag && $stable(rx_data)) // R12
        else $error("overrun lost the unread byte");
    AST_OVR_CLEAR: assert property ((rd_status && !done) |=> !overrun_flag) // R13
        else $error("status read left overrun set");
    AST_DONE_SET: assert property (done |=> transfer_done_flag) // R14
        else $error("completed byte did not set done");
    AST_DONE_IRQ: assert property ((!tx_empty_int_enable && transfer_done_flag) |-> IRQ_TX) // R15
        else $error("done flag raised no transmit request");
    AST_IDLE_LEVEL: assert property ((!m_busy && master_select_bit) ##1 $stable(clock_idle_polarity) |-> SCK_O == clock_idle_polarity) // R18
        else $error("master clock not at idle level");
    AST_FAULT_IRQ: assert property ((!fault_int_enable) |-> !IRQ_FAULT) // R20
        else $error("fault request while disabled");

    COV_MASTER_DONE: cover property (master_select_bit && done);
    COV_SLAVE_DONE: cover property (!master_select_bit && done);
    COV_OVERRUN: cover property (done && transfer_done_flag);
    COV_FAULT: cover property (fault_m || fault_s);
endmodule

// ===== sim/spimsp_partner.sv
// Behavioural external slave on the far side of the master port.
`timescale 1ns/1ps
module spimsp_partner (
    // Serial pins seen from the slave.
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Captured byte and reply byte.
    output logic [7:0]      got,
    input  wire logic [7:0] load
);
    logic [7:0] sh;
    // Take the reply once the bench has settled it.
    initial begin
        #1 sh = load;
    end
    // Sample on the leaving edge, as phase zero asks of both ends.
    always @(posedge sck) begin
        got <= {got[6:0], mosi};
    end
    // Shift on the returning edge; spent bits toggle so stale data never looks valid.
    always @(negedge sck) begin
        sh <= {sh[6:0], ~sh[7]};
    end
    assign miso = sh[7];
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the serial port in master mode, plus a slave deselect fault check.
`timescale 1ns/1ps
module tb_top;
    logic CLK, RESET, CYC_I, STB_I, WE_I, SS_N_I, ACK_O, SCK_O, SCK_OE_N, MOSI_O;
    logic MOSI_OE_N, MISO_O, MISO_OE_N, IRQ_TX, IRQ_FAULT, miso;
    logic [9:0] ADR_I;
    logic [3:0] SEL_I;
    logic [31:0] DAT_I, DAT_O;
    logic [7:0] got, q;
    int n_errors = 0;
    int n_compared = 0;
    spimsp_top dut_u (.CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .SCK_I(SCK_OE_N ? 1'b0 : SCK_O), .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N),
        .MOSI_I(MOSI_O), .MOSI_O(MOSI_O), .MOSI_OE_N(MOSI_OE_N), .MISO_I(miso),
        .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N), .SS_N_I(SS_N_I), .IRQ_TX(IRQ_TX),
        .IRQ_FAULT(IRQ_FAULT));
    spimsp_partner far_u (.sck(SCK_O), .mosi(MOSI_O), .miso(miso), .got(got), .load(8'h3c));
    // A 25 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        n_compared++;
        if (a !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, a, e);
        end
    endtask
    // Classic single cycle; waits for ack without assuming its latency.
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        CYC_I <= 1'b1; STB_I <= 1'b1; WE_I <= w; ADR_I <= a; DAT_I <= {24'h0, d};
        SEL_I <= 4'h1;
        do begin
            @(posedge CLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        q = DAT_O[7:0];
        if (n >= 50) chk(1'b0, 1'b1);
        CYC_I <= 1'b0; STB_I <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic t_reset();
        wb(0, 10'h350, 0); chk(q, 8'h14);
        wb(0, 10'h354, 0); chk(q, 8'h08);
        wb(0, 10'h3fc, 0); chk(q, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_master();
        wb(1, 10'h350, 8'h52);
        wb(1, 10'h358, 8'ha5);
        q = 0;
        for (int i = 0; i < 40 && q[7] !== 1'b1; i++) wb(0, 10'h354, 0);
        chk(q, 8'h88);
        chk(IRQ_TX, 1'b1);
        chk(SCK_O, 1'b0);
        chk(got, 8'ha5);
        wb(0, 10'h358, 0); chk(q, 8'h3c);
        wb(0, 10'h354, 0); chk(q, 8'h08);
        $display("master test done");
    endtask
    task automatic t_fault();
        wb(1, 10'h354, 8'h01);
        SS_N_I <= 1'b0;
        repeat (6) @(posedge CLK);
        wb(0, 10'h350, 0); chk(q, 8'h02);
        wb(0, 10'h354, 0); chk(q, 8'h19);
        chk(IRQ_FAULT, 1'b1);
        SS_N_I <= 1'b1;
        wb(1, 10'h350, 8'h01);
        wb(0, 10'h354, 0); chk(q, 8'h09);
        chk(IRQ_FAULT, 1'b0);
        wb(1, 10'h350, 8'h41);
        SS_N_I <= 1'b0;
        repeat (4) @(posedge CLK);
        SS_N_I <= 1'b1;
        repeat (4) @(posedge CLK);
        wb(0, 10'h354, 0); chk(q, 8'h19);
        $display("fault test done");
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence after three cycles of reset.
    initial begin
        RESET = 1; CYC_I = 0; STB_I = 0; WE_I = 0; ADR_I = 0; SEL_I = 4'h1; DAT_I = 0;
        SS_N_I = 1;
        repeat (3) @(posedge CLK);
        RESET <= 0;
        @(posedge CLK);
        t_reset();
        t_master();
        t_fault();
        give_verdict();
    end
    // Watchdog well past the 130 or so cycles the tests need.
    initial begin
        #200000 n_errors++;
        give_verdict();
    end
endmodule
